// *** hw/cci_top.sv ***
// Purpose: multiplier counters of N_UNITS integrator units on one card and their fast integrators.
// Assumes: samples and strobe come from logic on mclk; controls are asynchronous.
// Notes:   integrator entries are not reset; the dump clear empties them.
`timescale 1ns/1ps
module cci_top #(
    parameter int N_UNITS = cci_pkg::UNITS_DEF,
    parameter int N_MULT  = cci_pkg::MULTS_DEF
) (
    input  wire logic                             mclk,
    input  wire logic                             srst,
    input  wire logic                             sample_strobe,
    input  wire logic [N_UNITS*N_MULT*2-1:0]      sample_a,
    input  wire logic [N_UNITS*N_MULT*2-1:0]      sample_b,
    input  wire logic                             blanking_interval,
    input  wire logic                             dump_interval,
    input  wire logic                             results_captured,
    input  wire logic                             mem_clear,
    input  wire logic                             integrator_select_0,
    input  wire logic                             integrator_select_1,
    input  wire logic                             integrator_select_2,
    input  wire logic                             card_select_line,
    input  wire logic                             result_ready,
    output logic                                  result_valid,
    output logic [cci_pkg::WORD_W-1:0]            result_data,
    output logic                                  result_bus_oe,
    output logic [cci_pkg::ADDR_W-1:0]            sweep_addr
);
    import cci_pkg::*;

    if (N_MULT > RAM_DEPTH || N_UNITS > 8 || N_UNITS < 1
        || N_MULT * INT_CYCLE_NS >= HOLD_NS) begin : g_check
        $error("cci_top: unit or multiplier count cannot be served");
    end

    if ((1 << ADDR_W) < RAM_DEPTH || CYCLE_CLKS > (1 << PHASE_W)
        || READ_CLKS >= CYCLE_CLKS) begin : g_timing_check
        $error("cci_top: sweep timing does not fit its counters");
    end

    // ------------------------------------------------------------
    // Control synchronisers
    // ------------------------------------------------------------
    logic [7:0] ctl_meta_reg;
    logic [7:0] ctl_reg;
    logic       blank_s;
    logic       dump_s;
    logic       capt_s;
    logic       clr_s;
    logic       card_s;
    logic [2:0] sel_s;

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctl_meta_reg <= 8'h00;
            ctl_reg      <= 8'h00;
        end else begin
            ctl_meta_reg <= {blanking_interval, dump_interval, results_captured, mem_clear,
                             card_select_line, integrator_select_2, integrator_select_1,
                             integrator_select_0};
            ctl_reg      <= ctl_meta_reg;
        end
    end
    assign {blank_s, dump_s, capt_s, clr_s, card_s, sel_s} = ctl_reg;

    // ------------------------------------------------------------
    // Multiplier counters
    // ------------------------------------------------------------
    logic [N_UNITS*N_MULT*2-1:0] buf_a_reg;
    logic [N_UNITS*N_MULT*2-1:0] buf_b_reg;
    logic                        strobe_reg;
    logic [LOW_W-1:0]  low_reg   [N_UNITS][N_MULT];
    logic [LOW_W-1:0]  low_next  [N_UNITS][N_MULT];
    logic [HIGH_W-1:0] high_reg  [N_UNITS][N_MULT];
    logic [HIGH_W-1:0] high_next [N_UNITS][N_MULT];
    logic              freeze;

    assign freeze = blank_s | dump_s;

    // Data buffers keep running so fresh samples are ready when a freeze ends.
    always_ff @(posedge mclk) begin
        buf_a_reg <= sample_a;
        buf_b_reg <= sample_b;
    end

    always_comb begin
        logic [2:0] sum;
        sum = 3'h0;
        for (int u = 0; u < N_UNITS; u++) begin
            for (int m = 0; m < N_MULT; m++) begin
                low_next[u][m]  = low_reg[u][m];
                high_next[u][m] = high_reg[u][m];
                sum = {1'b0, low_reg[u][m]}
                    + {1'b0, cci_offset_product(buf_a_reg[(u*N_MULT+m)*2 +: 2],
                                                buf_b_reg[(u*N_MULT+m)*2 +: 2])};
                if (freeze) begin
                    low_next[u][m] = '0;
                end else if (strobe_reg) begin
                    low_next[u][m] = sum[1:0];
                    if (sum[2]) begin
                        high_next[u][m] = high_reg[u][m] + 8'h01;
                    end
                end
                if (dump_s && capt_s) begin
                    high_next[u][m] = '0;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            strobe_reg <= 1'b0;
            for (int u = 0; u < N_UNITS; u++) begin
                for (int m = 0; m < N_MULT; m++) begin
                    low_reg[u][m]  <= '0;
                    high_reg[u][m] <= '0;
                end
            end
        end else begin
            strobe_reg <= sample_strobe;
            low_reg    <= low_next;
            high_reg   <= high_next;
        end
    end

    // ------------------------------------------------------------
    // Fast integrator sweep
    // ------------------------------------------------------------
    logic [PHASE_W-1:0] phase_reg;
    logic [PHASE_W-1:0] phase_next;
    logic [ADDR_W-1:0]  addr_reg;
    logic [ADDR_W-1:0]  addr_next;
    logic [ENTRY_W-1:0] latch_reg [N_UNITS];
    logic [ENTRY_W-1:0] latch_next[N_UNITS];
    logic [N_UNITS-1:0] sync_reg;
    logic [N_UNITS-1:0] sync_next;
    logic [N_UNITS-1:0] second_top_bit_reg;
    logic [N_UNITS-1:0] second_top_bit_next;
    logic [ENTRY_W-1:0] mem_reg   [N_UNITS][RAM_DEPTH];
    logic [ENTRY_W-1:0] wr_data   [N_UNITS];
    logic               wr_en;
    logic               cycle_end;
    logic               push_req;
    logic               stall;
    logic               oe_next;
    logic [ADDR_W-1:0]  addr_out_next;

    cci_stream_if #(.WIDTH(WORD_W)) push_if ();
    cci_stream_if #(.WIDTH(WORD_W)) pop_if ();

    assign cycle_end = (phase_reg == PHASE_LAST);
    assign push_req  = dump_s & card_s & (int'(sel_s) < N_UNITS);
    // A full queue holds the sweep rather than losing a dumped word.
    assign stall     = cycle_end & push_req & ~push_if.ready;
    assign wr_en     = cycle_end & ~stall;

    assign push_if.valid = cycle_end & push_req;
    assign push_if.data  = {addr_reg, second_top_bit_reg[sel_s], latch_reg[sel_s]};
    assign pop_if.ready  = result_ready;

    always_comb begin
        phase_next = stall ? phase_reg : (cycle_end ? PHASE_RST : phase_reg + 6'h01);
        addr_next  = addr_reg;
        if (wr_en) begin
            addr_next = (addr_reg == ADDR_W'(N_MULT - 1)) ? ADDR_RST : addr_reg + 4'h1;
        end
        addr_out_next = addr_next;
        oe_next       = dump_s & card_s;
        sync_next     = sync_reg;
        second_top_bit_next     = second_top_bit_reg;
        for (int u = 0; u < N_UNITS; u++) begin
            latch_next[u] = latch_reg[u];
            if (phase_reg == PHASE_LATCH) begin
                latch_next[u] = mem_reg[u][addr_reg];
            end
            // Carry from old bit one and inverted present bit one, i.e. a falling edge.
            wr_data[u] = {latch_reg[u][ENTRY_W-1:1]
                          + 6'(latch_reg[u][0] & ~sync_reg[u]), sync_reg[u]};
            if (clr_s) begin
                wr_data[u] = '0;
            end
            if (wr_en) begin
                sync_next[u] = high_reg[u][addr_reg][HIGH_W-1];
                second_top_bit_next[u] = high_reg[u][addr_reg][HIGH_W-2];
            end
        end
    end

    // Synchroniser and latch carry no reset; cleared multipliers and a cleared memory feed them zeros.
    always_ff @(posedge mclk) begin
        sync_reg   <= sync_next;
        second_top_bit_reg   <= second_top_bit_next;
        latch_reg  <= latch_next;
        if (wr_en) begin
            for (int u = 0; u < N_UNITS; u++) begin
                mem_reg[u][addr_reg] <= wr_data[u];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            phase_reg     <= PHASE_RST;
            addr_reg      <= ADDR_RST;
            sweep_addr    <= ADDR_RST;
            result_bus_oe <= 1'b0;
        end else begin
            phase_reg     <= phase_next;
            addr_reg      <= addr_next;
            sweep_addr    <= addr_out_next;
            result_bus_oe <= oe_next;
        end
    end

    cci_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk   (mclk),
        .srst   (srst),
        .in_if  (push_if),
        .out_if (pop_if)
    );
    assign result_valid = pop_if.valid;
    assign result_data  = pop_if.data;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    logic low_any;
    logic high_any;
    always_comb begin
        low_any  = 1'b0;
        high_any = 1'b0;
        for (int u = 0; u < N_UNITS; u++) begin
            for (int m = 0; m < N_MULT; m++) begin
                low_any  = low_any | (|low_reg[u][m]);
                high_any = high_any | (|high_reg[u][m]);
            end
        end
    end

    sequence s_write;
        cycle_end && !stall;
    endsequence
    sequence s_cycle_start;
        phase_reg == PHASE_RST;
    endsequence
    sequence s_counting;
        strobe_reg && !freeze;
    endsequence

    a_freeze_low_stages: assert property (freeze |=> !low_any)
        else $error("first stages not held at zero during freeze");
    a_dump_clear_high: assert property (dump_s && capt_s |=> !high_any)
        else $error("later stages not cleared after capture");
    a_read_phase_len: assert property (s_cycle_start |-> ##23 phase_reg == PHASE_LATCH)
        else $error("read phase is not twenty four cycles");
    a_cycle_wrap: assert property (s_write |=> s_cycle_start ##35 cycle_end)
        else $error("integrator cycle is not thirty six cycles");
    a_addr_sweep: assert property (s_write |=> addr_reg ==
            ($past(addr_reg) == 4'hD ? 4'h0 : $past(addr_reg) + 4'h1))
        else $error("address sweep does not step over fourteen entries");
    a_sel_matches: assert property (s_write |=> sweep_addr == addr_reg)
        else $error("selector index differs from memory address");
    a_lsb_present: assert property (s_write and !clr_s |=>
            mem_reg[0][$past(addr_reg)][0] == $past(sync_reg[0]))
        else $error("entry low bit is not the present input");
    a_edge_count: assert property (s_write and (!clr_s && latch_reg[0][0] && !sync_reg[0]) |=>
            mem_reg[0][$past(addr_reg)][6:1] == $past(latch_reg[0][6:1]) + 6'h01)
        else $error("falling edge not counted");
    a_no_edge_hold: assert property (s_write and (!clr_s && !(latch_reg[0][0] && !sync_reg[0]))
            |=> mem_reg[0][$past(addr_reg)][6:1] == $past(latch_reg[0][6:1]))
        else $error("count changed without a falling edge");
    a_lag_one: assert property (s_write |=>
            sync_reg[0] == $past(high_reg[0][addr_reg][HIGH_W-1]))
        else $error("synchroniser did not take the selected multiplier");
    a_mem_cleared: assert property (s_write and clr_s |=> mem_reg[0][$past(addr_reg)] == '0)
        else $error("entry not cleared during dump clear");
    a_oe_on: assert property (dump_s && card_s |=> result_bus_oe)
        else $error("bus enable not raised for a selected dump");
    a_oe_off: assert property (!(dump_s && card_s) |=> !result_bus_oe)
        else $error("bus enable raised outside a selected dump");
    a_frozen_high: assert property (freeze && !capt_s |=> $stable(high_reg[0][0]))
        else $error("later stages moved while frozen");

    // Slot checks watch unit zero, whose first three multipliers see each product kind.
    a_zero_holds: assert property (s_counting and
            cci_offset_product(buf_a_reg[1:0], buf_b_reg[1:0]) == 2'h0
            |=> $stable(low_reg[0][0]) && $stable(high_reg[0][0]))
        else $error("a product of zero changed the count");
    a_one_steps: assert property (s_counting and
            cci_offset_product(buf_a_reg[3:2], buf_b_reg[3:2]) == 2'h1
            |=> low_reg[0][1] == $past(low_reg[0][1]) + 2'h1)
        else $error("a product of one did not step the first stage");
    a_two_carries: assert property (s_counting and low_reg[0][2] == 2'h2 and
            cci_offset_product(buf_a_reg[5:4], buf_b_reg[5:4]) == 2'h2
            |=> low_reg[0][2] == 2'h0 && high_reg[0][2] == $past(high_reg[0][2]) + 8'h01)
        else $error("a product of two did not carry into the later stages");
endmodule

// *** hw/cci_pkg.sv ***
// What this block does
// - Each sample product is offset by one, giving counts 2, 1 or 0.
// - Each multiplier adds one, adds two or holds on every sample.
// - Stage one counts ones; stage two counts twos plus stage-one carry, synchronously.
// - Stage two carry steps a four-bit counter whose top bit steps another.
// - Top bit and next-to-top bit of each multiplier go through two selectors.
// - Selector index equals the integrator memory address at all times.
// - Blanking or dump holds the first two stages of every multiplier at zero.
// - In dump, after capture, the later multiplier stages are cleared to zero.
// - Sample data buffers are never reset by blanking or dump.
// - Six integrator units, each for fourteen multipliers, seven-bit results.
// - Selected bit is registered once per integrator cycle, true and inverted used.
// - Integrator cycle is 180 ns: 120 ns read then 60 ns write.
// - Fourteen of sixteen addresses are swept, faster than the 2.56 us hold.
// - Count gains one only when old stored bit is one and new bit zero.
// - Write back to the same entry, low bit set to the present input.
// - The accumulated multiplier lags the selected one by exactly one address.
// - The sweep runs on through blanking; results stay constant.
// - In dump, results go to a shared bus chosen by unit and card selects.
// - After transfer, still in dump, memories are cleared while sweeping on.
// - The bit synchroniser has no reset; zeros flow in after multipliers clear.
// Purpose: constants shared by the correlator count integrator.
// Assumes: one 200 MHz clock; sample strobe marks each sample.
// Notes:   none.
package cci_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int UNITS_DEF  = 6;
    localparam int MULTS_DEF  = 14;
    localparam int RAM_DEPTH  = 16;
    localparam int ADDR_W     = 4;
    localparam int ENTRY_W    = 7;
    localparam int LOW_W      = 2;
    localparam int HIGH_W     = 8;
    localparam int PHASE_W    = 6;
    localparam int FIFO_DEPTH = 16;
    localparam int WORD_ENTRY_LSB = 0;
    localparam int WORD_SECOND_TOP_BIT_POS  = 7;
    localparam int WORD_ADDR_LSB  = 8;
    localparam int WORD_W         = 12;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 200;
    localparam int INT_CYCLE_NS = 180;
    localparam int READ_NS      = 120;
    localparam int WRITE_NS     = 60;
    localparam int HOLD_NS      = 2560;
    localparam int CYCLE_CLKS   = INT_CYCLE_NS * CLK_MHZ / 1000;
    localparam int READ_CLKS    = (READ_NS * CLK_MHZ + 999) / 1000;
    localparam int WRITE_CLKS   = CYCLE_CLKS - READ_CLKS;
    localparam logic [PHASE_W-1:0] PHASE_LAST  = PHASE_W'(CYCLE_CLKS - 1);
    localparam logic [PHASE_W-1:0] PHASE_LATCH = PHASE_W'(READ_CLKS - 1);
    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [PHASE_W-1:0] PHASE_RST = 6'h00;
    localparam logic [ADDR_W-1:0]  ADDR_RST  = 4'h0;
    localparam logic [1:0] SMP_ZERO  = 2'h0;
    localparam logic [1:0] SMP_PLUS  = 2'h1;
    localparam logic [1:0] SMP_MINUS = 2'h3;

    // Offset product: same signs give 2, a zero gives 1, opposite signs give 0.
    function automatic logic [1:0] cci_offset_product(input logic [1:0] a,
                                                      input logic [1:0] b);
        if (a == SMP_ZERO || b == SMP_ZERO || a == 2'h2 || b == 2'h2) begin
            return 2'h1;
        end
        return (a == b) ? 2'h2 : 2'h0;
    endfunction
endpackage

// *** hw/cci_stream_if.sv ***
// Purpose: valid/ready word channel between the block's own modules.
// Assumes: both ends on mclk.
// Notes:   a word moves on a cycle with valid and ready both high.
`timescale 1ns/1ps
interface cci_stream_if #(parameter int WIDTH = 12);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// *** hw/cci_fifo.sv ***
// Purpose: shift-register FIFO whose head and flags come from flip-flops.
// Assumes: single clock, synchronous reset.
// Notes:   head is always entry zero, so the output needs no read mux.
`timescale 1ns/1ps
module cci_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input  wire logic    mclk,
    input  wire logic    srst,
    cci_stream_if.snk    in_if,
    cci_stream_if.src    out_if
);
    import cci_pkg::*;
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || WIDTH < 1) begin : g_check
        $error("cci_fifo: depth must be at least two");
    end

    logic [WIDTH-1:0] mem_reg  [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [CW-1:0]    count_reg;
    logic [CW-1:0]    count_next;
    logic             valid_reg;
    logic             valid_next;
    logic             full_reg;
    logic             full_next;
    logic             push;
    logic             pop;

    assign push         = in_if.valid & ~full_reg;
    assign pop          = out_if.ready & valid_reg;
    assign in_if.ready  = ~full_reg;
    assign out_if.valid = valid_reg;
    assign out_if.data  = mem_reg[0];

    always_comb begin
        logic [CW-1:0] wr_idx;
        wr_idx = count_reg - CW'(pop);
        for (int i = 0; i < DEPTH; i++) begin
            mem_next[i] = mem_reg[i];
            if (pop && i < DEPTH - 1) begin
                mem_next[i] = mem_reg[i+1];
            end
            if (push && CW'(i) == wr_idx) begin
                mem_next[i] = in_if.data;
            end
        end
        count_next = count_reg + CW'(push) - CW'(pop);
        valid_next = (count_next != '0);
        full_next  = (count_next == CW'(DEPTH));
    end

    always_ff @(posedge mclk) begin
        mem_reg <= mem_next;
        if (srst) begin
            count_reg <= '0;
            valid_reg <= 1'b0;
            full_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            valid_reg <= valid_next;
            full_reg  <= full_next;
        end
    end
endmodule

// *** test/cci_hold_store_model.sv ***
// Purpose: behavioural holding store that takes result words off the dump bus.
// Assumes: words move on a rising edge with result_valid and result_ready high.
// Notes:   ready is random while running, so both prompt and slow takes occur.
`timescale 1ns/1ps
module cci_hold_store_model (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        stall,
    input  wire logic        result_valid,
    input  wire logic [11:0] result_data,
    output logic             result_ready,
    output int               slow_falls
);
    int   seed;
    logic top_prev [16];

    // ------------------------------------------------------------
    // Ready generation
    // ------------------------------------------------------------
    // Ready changes just after the edge, so the design sees it settled.
    initial begin
        seed = 61502;
        result_ready = 1'b0;
        forever begin
            @(posedge mclk);
            #1;
            result_ready = !srst && !stall && ($random(seed) & 1);
        end
    end

    // ------------------------------------------------------------
    // Slow integration
    // ------------------------------------------------------------
    // Each entry's top bit is edge-counted per address, as the fast side does.
    initial begin
        slow_falls = 0;
        foreach (top_prev[i]) top_prev[i] = 1'b0;
        forever begin
            @(negedge mclk);
            if (result_valid === 1'b1 && result_ready === 1'b1) begin
                if (top_prev[result_data[11:8]] && !result_data[6]) slow_falls++;
                top_prev[result_data[11:8]] = result_data[6];
            end
        end
    end
endmodule

// *** test/correlator_count_integrator_tb.sv ***
// Purpose: self-checking bench for the multiplier counters and fast integrator.
// Assumes: default sizes of six units with fourteen multipliers each.
// Notes:   expected dump words are noted in a queue and matched at the bus.
`timescale 1ns/1ps
module correlator_count_integrator_tb;
    import cci_pkg::*;

    logic          mclk;
    logic          srst;
    logic          sample_strobe;
    logic [167:0]  sample_a;
    logic [167:0]  sample_b;
    logic          blanking_interval;
    logic          dump_interval;
    logic          results_captured;
    logic          mem_clear;
    logic [2:0]    unit_sel;
    logic          card_select_line;
    logic          result_ready;
    logic          result_valid;
    logic [11:0]   result_data;
    logic          result_bus_oe;
    logic [3:0]    sweep_addr;
    logic          stall;
    logic [1:0]    kind [84];
    logic [11:0]   exp_q [$];
    int            n_fail;
    int            n_checks;
    int            seed;
    int            u;
    int            slow_falls;

    cci_top i_dut (
        .mclk                (mclk),
        .srst                (srst),
        .sample_strobe       (sample_strobe),
        .sample_a            (sample_a),
        .sample_b            (sample_b),
        .blanking_interval   (blanking_interval),
        .dump_interval       (dump_interval),
        .results_captured    (results_captured),
        .mem_clear           (mem_clear),
        .integrator_select_0 (unit_sel[0]),
        .integrator_select_1 (unit_sel[1]),
        .integrator_select_2 (unit_sel[2]),
        .card_select_line    (card_select_line),
        .result_ready        (result_ready),
        .result_valid        (result_valid),
        .result_data         (result_data),
        .result_bus_oe       (result_bus_oe),
        .sweep_addr          (sweep_addr)
    );

    cci_hold_store_model i_store (
        .mclk         (mclk),
        .srst         (srst),
        .stall        (stall),
        .result_valid (result_valid),
        .result_data  (result_data),
        .result_ready (result_ready),
        .slow_falls   (slow_falls)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Strobes at half the clock rate; the counters would accept a strobe on every clock.
    task automatic strobes(input int n);
        repeat (n) begin
            sample_strobe = 1'b1;
            tick(1);
            sample_strobe = 1'b0;
            tick(1);
        end
    endtask

    // Count 1600 samples: twos give three falls and 128, ones one fall and 576.
    function automatic logic [6:0] ent_val(input logic [1:0] k);
        return (k == 2'h2) ? 7'h06 : (k == 2'h1) ? 7'h03 : 7'h00;
    endfunction

    task automatic clear_all;
        card_select_line = 1'b0;
        dump_interval = 1'b1;
        results_captured = 1'b1;
        mem_clear = 1'b1;
        tick(16 * CYCLE_CLKS);
        chk(result_bus_oe, 0);
        chk(result_valid, 0);
        dump_interval = 1'b0;
        results_captured = 1'b0;
        mem_clear = 1'b0;
        tick(CYCLE_CLKS);
    endtask

    task automatic read_dump(input int nw, input logic zero, input logic hold);
        logic [3:0] a;
        logic [3:0] a0;
        logic [3:0] k;
        int         c;
        int         seen;
        a = sweep_addr;
        c = 0;
        while (sweep_addr === a && c < 100) begin
            tick(1);
            c++;
        end
        a0 = sweep_addr;
        for (int i = 0; i < nw; i++) begin
            k = 4'((a0 + i) % 14);
            exp_q.push_back({k, 1'b0, zero ? 7'h00 : ent_val(kind[u*14 + (k + 13) % 14])});
        end
        stall = hold;
        unit_sel = 3'(u);
        card_select_line = 1'b1;
        dump_interval = 1'b1;
        a = a0;
        seen = 0;
        c = 0;
        while (seen < nw && c < 5000) begin
            tick(1);
            c++;
            if (sweep_addr !== a) begin
                seen++;
                a = sweep_addr;
            end
            if (c == 10) chk(result_bus_oe, 1);
            if (hold && c == 750) begin
                // A full queue holds the sweep on the seventeenth address.
                chk(sweep_addr, (a0 + 16) % 14);
                chk(result_valid, 1);
                stall = 1'b0;
            end
        end
        dump_interval = 1'b0;
        card_select_line = 1'b0;
        c = 0;
        while (exp_q.size() > 0 && c < 300) begin
            tick(1);
            c++;
        end
        chk(exp_q.size(), 0);
        chk(result_valid, 0);
    endtask

    // ------------------------------------------------------------
    // Clock, monitor, watchdog
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Sampled at the falling edge: a word seen here moves at the next rise.
    always @(negedge mclk) begin
        if (result_valid === 1'b1 && result_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk({20'h0, result_data}, 32'hFFFF_FFFF);
            end else begin
                chk({20'h0, result_data}, {20'h0, exp_q.pop_front()});
            end
        end
    end

    initial begin
        #100000;
        n_fail++;
        test_done;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [3:0] a;
        logic [1:0] s;
        int         c;
        int         r;
        n_fail = 0;
        n_checks = 0;
        seed = 61502;
        srst = 1'b1;
        sample_strobe = 1'b0;
        sample_a = '0;
        sample_b = '0;
        blanking_interval = 1'b0;
        dump_interval = 1'b0;
        results_captured = 1'b0;
        mem_clear = 1'b0;
        unit_sel = 3'h0;
        card_select_line = 1'b0;
        stall = 1'b1;
        tick(3);
        chk({result_valid, result_bus_oe, sweep_addr}, 0);
        srst = 1'b0;
        clear_all;
        a = sweep_addr;
        for (int i = 0; i < 16; i++) begin
            c = 0;
            while (sweep_addr === a && c < 100) begin
                tick(1);
                c++;
            end
            if (i > 0) chk(c, CYCLE_CLKS);
            chk(sweep_addr, (a + 1) % 14);
            a = sweep_addr;
        end
        for (int i = 0; i < 84; i++) begin
            r = $random(seed);
            kind[i] = (i < 3) ? 2'(i) : 2'($unsigned(r) % 3);
            s = r[4] ? SMP_MINUS : SMP_PLUS;
            sample_a[i*2 +: 2] = (kind[i] == 2'h1) ? (r[5] ? 2'h2 : SMP_ZERO) : s;
            sample_b[i*2 +: 2] = (kind[i] == 2'h0) ? ((s == SMP_PLUS) ? SMP_MINUS : SMP_PLUS) : s;
        end
        u = $unsigned($random(seed)) % 6;
        strobes(1600);
        tick(20);
        blanking_interval = 1'b1;
        tick(10);
        strobes(150);
        tick(10);
        blanking_interval = 1'b0;
        tick(4 * CYCLE_CLKS * 14);
        read_dump(28, 1'b0, 1'b1);
        clear_all;
        read_dump(14, 1'b1, 1'b0);
        chk(slow_falls, 0);
        test_done;
    end
endmodule
